/* core/sync_cmd_pkg.sv */
// sync_cmd_pkg: constants, enums and carriers for the common-command engine
// assumes a parser upstream that decodes commands into cmd_s words
package sync_cmd_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned SETTLE_MS    = 1000;
  localparam int unsigned SETTLE_CYC   = CLK_HZ / 1000 * SETTLE_MS;

  // ==========================================================
  // field positions and values
  localparam int unsigned STB_MAV      = 4;
  localparam int unsigned STB_ESB      = 5;
  localparam int unsigned STB_RQS      = 6;
  localparam int unsigned ESR_OPC      = 0;
  localparam int unsigned SRE_MAV      = 4;
  localparam int unsigned SRE_ESB      = 5;
  localparam logic [7:0]  OPC_CHAR     = 8'h31;
  localparam logic [6:0]  FILE_MAX     = 7'h63;
  localparam int unsigned NUM_EVREG    = 8;
  localparam int unsigned NUM_MEAS     = 8;
  localparam int unsigned CMDQ_DEPTH   = 4;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;

  // ==========================================================
  // command codes
  typedef enum logic [3:0] {
    CMD_NOP  = 4'h0,
    CMD_OPC  = 4'h1,
    CMD_OPCQ = 4'h2,
    CMD_WAI  = 4'h3,
    CMD_CLS  = 4'h4,
    CMD_TRG  = 4'h5,
    CMD_RCL  = 4'h6,
    CMD_SAV  = 4'h7,
    CMD_OTHR = 4'h8
  } cmd_code_e;

  typedef struct packed {
    cmd_code_e  code;
    logic       numeric;   // argument was all digits
    logic [6:0] file_num;  // binary value of the argument
  } cmd_s;

  typedef struct packed {
    logic       valid;
    logic       is_save;
    logic [6:0] file_num;
  } store_req_s;

endpackage

/* core/settle_timer.sv */
// settle_timer: one-shot down counter for the post-command settling delay
// assumes start is a one-cycle pulse on mclk
`timescale 1ns/1ps
module settle_timer #(
  parameter int unsigned CYCLES = sync_cmd_pkg::SETTLE_CYC
) (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic start,
  output logic      expired
);

  logic [31:0] count_q;

  // ==========================================================
  // restart on every start pulse; expired holds until next start
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      count_q <= 32'h0000_0000;
    end else if (start) begin
      count_q <= CYCLES - 1;
    end else if (count_q != 32'h0000_0000) begin
      count_q <= count_q - 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      expired <= 1'b0;
    end else if (start) begin
      expired <= 1'b0;
    end else if (count_q == 32'h0000_0001 || CYCLES == 1) begin
      expired <= 1'b1;
    end
  end

endmodule // settle_timer

/* core/sync_cmd_engine.sv */
// sync_cmd_engine: executes sync, clear, trigger, save and recall commands
// assumes decoded commands on mclk, measurement done flags on mclk, and an
// output queue that drains bytes the engine pushes
`timescale 1ns/1ps
module sync_cmd_engine #(
  parameter int unsigned SETTLE = sync_cmd_pkg::SETTLE_CYC
) (
  input  wire logic                       mclk,
  input  wire logic                       reset,
  // command stream from the parser
  input  wire logic                       cmd_valid,
  input  wire sync_cmd_pkg::cmd_s         cmd_in,
  output logic                            cmd_ready,
  // measurement side
  input  wire logic [7:0]                 meas_active,
  input  wire logic [7:0]                 meas_done,
  output logic                            meas_done_req,
  output logic                            meas_trigger,
  input  wire logic                       get_msg,
  // other command completion (from instrument firmware)
  output logic                            other_start,
  input  wire logic                       other_busy,
  // output queue
  output logic                            oq_push,
  output logic [7:0]                      oq_data,
  input  wire logic                       oq_ready,
  input  wire logic                       oq_not_empty,
  // status registers
  input  wire logic [7:0]                 sre_mask,
  input  wire logic [7:0]                 ese_mask,
  input  wire logic [7:0]                 evreg_set,
  input  wire logic [7:0]                 esr_set,
  output logic [7:0]                      esr_q,
  output logic [7:0]                      evreg_sum_q,
  output logic [7:0]                      stb_q,
  output logic                            srq,
  output logic                            error_queue_flush,
  output logic                            bad_file_error,
  // save/recall storage
  output sync_cmd_pkg::store_req_s        store_req,
  input  wire logic                       store_busy,
  // message log, power-on only
  input  wire logic                       log_write,
  output logic                            log_present_q
);


  // ==========================================================
  // local state encoding
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,  // ready for the next command
    ST_SYNC  = 3'b001,  // settling timer and measurement wait
    ST_PUSH  = 3'b010,  // offering the completion byte
    ST_OTHER = 3'b011,  // firmware runs a non-common command
    ST_STORE = 3'b100   // save or recall in progress
  } state_e;

  // ==========================================================
  // helpers
  // decode shared by the take path and the strobes
  function automatic logic is_sync(
    input sync_cmd_pkg::cmd_code_e code
  );
    return (code == sync_cmd_pkg::CMD_OPC)  ||
           (code == sync_cmd_pkg::CMD_OPCQ) ||
           (code == sync_cmd_pkg::CMD_WAI);
  endfunction

  // save and recall share one argument path
  function automatic logic is_store(
    input sync_cmd_pkg::cmd_code_e code
  );
    return (code == sync_cmd_pkg::CMD_SAV) ||
           (code == sync_cmd_pkg::CMD_RCL);
  endfunction

  // only all-digit numbers up to the top slot are legal here; any other
  // name must go through the named-file commands instead
  function automatic logic file_ok(
    input sync_cmd_pkg::cmd_s cmd
  );
    return cmd.numeric && (cmd.file_num <= sync_cmd_pkg::FILE_MAX);
  endfunction

  // one-hot mask for a status or event bit position
  function automatic logic [7:0] bit_mask(
    input int unsigned idx
  );
    return 8'h01 << idx;
  endfunction

  // ==========================================================
  // declarations
  state_e                  state_q;
  state_e                  state_d;
  sync_cmd_pkg::cmd_code_e sync_kind_q;  // which sync command waits
  logic [7:0]              pending_q;    // measurements not yet done
  logic                    stuck_q;      // an awaited one went away
  logic                    take;
  logic                    take_sync;
  logic                    take_cls;
  logic                    take_trg;
  logic                    take_other;
  logic                    take_store;
  logic                    store_good;
  logic                    settle_done;
  logic                    sync_met;
  logic                    finish_opc;
  logic                    finish_opcq;
  logic [7:0]              opc_mask;
  logic [7:0]              stb_d;
  logic                    srq_sum;
  logic                    srq_sum_q;
  logic                    srq_rise;

  // ==========================================================
  // command acceptance
  // one command at a time: a held command waits at the input with its
  // valid up, so order is kept and nothing is dropped
  assign cmd_ready  = (state_q == ST_IDLE);
  assign take       = cmd_valid && cmd_ready;
  assign take_sync  = take && is_sync(cmd_in.code);
  assign take_cls   = take && (cmd_in.code == sync_cmd_pkg::CMD_CLS);
  assign take_trg   = take && (cmd_in.code == sync_cmd_pkg::CMD_TRG);
  assign take_other = take && (cmd_in.code == sync_cmd_pkg::CMD_OTHR);
  assign take_store = take && is_store(cmd_in.code);
  assign store_good = file_ok(cmd_in);

  // ==========================================================
  // settling timer
  // output settling cannot be observed, so a fixed delay stands
  settle_timer #(
    .CYCLES (SETTLE)
  ) i_settle (
    .mclk    (mclk),
    .reset   (reset),
    .start   (take_sync),
    .expired (settle_done)
  );

  // ==========================================================
  // sync condition
  // done flags are ignored while the request is still going out, since
  // the measurements then still show the answer to an older request
  assign sync_met    = settle_done && (pending_q == 8'h00) && !stuck_q &&
                       !meas_done_req && !other_busy;
  assign finish_opc  = (state_q == ST_SYNC) && sync_met &&
                       (sync_kind_q == sync_cmd_pkg::CMD_OPC);
  assign finish_opcq = (state_q == ST_SYNC) && sync_met &&
                       (sync_kind_q == sync_cmd_pkg::CMD_OPCQ);
  assign opc_mask    = finish_opc ? bit_mask(sync_cmd_pkg::ESR_OPC)
                                  : 8'h00;

  // ==========================================================
  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (take_sync) begin
          state_d = ST_SYNC;
        end else if (take_other) begin
          state_d = ST_OTHER;
        end else if (take_store && store_good) begin
          state_d = ST_STORE;
        end
      end
      ST_SYNC: begin
        // a query answers only after everything before it is done
        if (finish_opcq) begin
          state_d = ST_PUSH;
        end else if (sync_met) begin
          state_d = ST_IDLE;
        end
      end
      ST_PUSH: begin
        // the byte stands until the queue takes it
        if (oq_ready) begin
          state_d = ST_IDLE;
        end
      end
      ST_OTHER: begin
        if (!other_busy && !other_start) begin
          state_d = ST_IDLE;
        end
      end
      ST_STORE: begin
        if (!store_busy && !store_req.valid) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // kind of sync command that armed the wait
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sync_kind_q <= sync_cmd_pkg::CMD_NOP;
    end else if (take_sync) begin
      sync_kind_q <= cmd_in.code;
    end
  end

  // ==========================================================
  // measurement wait
  // every active measurement is asked once per sync command
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      meas_done_req <= 1'b0;
    end else begin
      meas_done_req <= take_sync;
    end
  end

  // bits clear as measurements report; snapshot of the active set
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pending_q <= 8'h00;
    end else if (take_sync) begin
      pending_q <= meas_active;
    end else if (state_q == ST_SYNC && !meas_done_req) begin
      pending_q <= pending_q & ~meas_done;
    end
  end

  // a measurement switched off while awaited never completes; the wait
  // is left outstanding on purpose, only reset recovers it
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      stuck_q <= 1'b0;
    end else if (take_sync) begin
      stuck_q <= 1'b0;
    end else if (state_q == ST_SYNC &&
                 (pending_q & ~meas_active) != 8'h00) begin
      stuck_q <= 1'b1;
    end
  end

  // ==========================================================
  // output queue
  // push is a handshake, the byte itself comes from a flop
  assign oq_push = (state_q == ST_PUSH);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      oq_data <= sync_cmd_pkg::BYTE_ZERO;
    end else if (finish_opcq) begin
      oq_data <= sync_cmd_pkg::OPC_CHAR;
    end
  end

  // ==========================================================
  // event registers
  // a set in the clear cycle wins, so no event is ever lost
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      esr_q <= 8'h00;
    end else if (take_cls) begin
      esr_q <= esr_set;
    end else begin
      esr_q <= esr_q | esr_set | opc_mask;
    end
  end

  // sticky summary of the other event registers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      evreg_sum_q <= 8'h00;
    end else if (take_cls) begin
      evreg_sum_q <= evreg_set;
    end else begin
      evreg_sum_q <= evreg_sum_q | evreg_set;
    end
  end

  // queued errors are dropped downstream on this strobe
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      error_queue_flush <= 1'b0;
    end else begin
      error_queue_flush <= take_cls;
    end
  end

  // ==========================================================
  // status byte
  // message-available follows the queue itself, so a clear leaves it
  always_comb begin
    stb_d                         = 8'h00;
    stb_d[3:0]                    = evreg_sum_q[3:0];
    stb_d[7]                      = |evreg_sum_q[7:4];
    stb_d[sync_cmd_pkg::STB_MAV]  = oq_not_empty;
    stb_d[sync_cmd_pkg::STB_ESB]  = |(esr_q & ese_mask);
    stb_d[sync_cmd_pkg::STB_RQS]  = srq;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      stb_q <= 8'h00;
    end else if (take_cls) begin
      stb_q <= stb_d & bit_mask(sync_cmd_pkg::STB_MAV);
    end else begin
      stb_q <= stb_d;
    end
  end

  // ==========================================================
  // service request
  // raised on a new enabled summary bit, not on its level, so that a
  // clear can withdraw it while the output queue still holds data
  assign srq_sum  = |(stb_q & sre_mask &
                      ~bit_mask(sync_cmd_pkg::STB_RQS));
  assign srq_rise = srq_sum && !srq_sum_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      srq_sum_q <= 1'b0;
    end else begin
      srq_sum_q <= srq_sum;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      srq <= 1'b0;
    end else if (srq_rise) begin
      srq <= 1'b1;
    end else if (take_cls) begin
      srq <= 1'b0;
    end
  end

  // ==========================================================
  // trigger
  // get_msg comes from the bus logic on mclk, so no synchroniser
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      meas_trigger <= 1'b0;
    end else begin
      meas_trigger <= take_trg || get_msg;
    end
  end

  // other commands run in firmware; the engine only keeps order
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      other_start <= 1'b0;
    end else begin
      other_start <= take_other;
    end
  end

  // ==========================================================
  // save and recall
  // the storage side picks the medium; only the slot number and the save/recall flag go out
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      store_req <= '0;
    end else begin
      store_req.valid    <= take_store && store_good;
      store_req.is_save  <= cmd_in.code == sync_cmd_pkg::CMD_SAV;
      store_req.file_num <= cmd_in.file_num;
    end
  end

  // refused slot numbers are flagged, never stored or recalled
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bad_file_error <= 1'b0;
    end else begin
      bad_file_error <= take_store && !store_good;
    end
  end

  // ==========================================================
  // message log
  // only power-on reset clears it; clear-status must not
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      log_present_q <= 1'b0;
    end else if (log_write) begin
      log_present_q <= 1'b1;
    end
  end

endmodule // sync_cmd_engine

/* dv/sync_cmd_engine_sva.sv */
// checker on the command engine ports
// assumes one mclk domain, reset async high
`timescale 1ns/1ps
module sync_chk(input wire logic mclk, reset, cmd_valid, cmd_ready,
  oq_push, oq_ready, srq, meas_trigger, error_queue_flush, log_present_q,
  input wire sync_cmd_pkg::cmd_s cmd_in,
  input wire logic [7:0] oq_data, stb_q, esr_q, evreg_sum_q, sre_mask,
  esr_set, evreg_set,
  input wire sync_cmd_pkg::store_req_s store_req);
  // ==========================================
  // properties
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire tk = cmd_valid && cmd_ready;
  wire [3:0] c = cmd_in.code;
  sequence s_opcq; tk && c == 4'h2; endsequence
  property p_char; oq_push |-> oq_data == 8'h31; endproperty
  property p_mav; oq_push && oq_ready |-> ##[1:3] stb_q[4]; endproperty
  property p_hold; s_opcq |-> !oq_push [*8]; endproperty
  property p_srq; $rose(stb_q[4]) && sre_mask[4] |-> ##[0:2] srq;
  endproperty
  property p_cls;
    tk && c == 4'h4 && esr_set == 0 && evreg_set == 0 |=>
      esr_q == 0 && evreg_sum_q == 0;
  endproperty
  property p_flush;
    tk && c == 4'h4 |-> ##[0:3] error_queue_flush;
  endproperty
  property p_trg; tk && c == 4'h5 |-> ##[0:3] meas_trigger; endproperty
  property p_file; store_req.valid |-> store_req.file_num <= 7'h63;
  endproperty
  property p_log; !$fell(log_present_q); endproperty
  a_char: assert property (p_char) else $error("bad answer");
  a_mav: assert property (p_mav) else $error("no mav");
  a_hold: assert property (p_hold) else $error("early answer");
  a_srq: assert property (p_srq) else $error("no srq");
  a_cls: assert property (p_cls) else $error("esr kept");
  a_flush: assert property (p_flush) else $error("no flush");
  a_trg: assert property (p_trg) else $error("no trigger");
  a_file: assert property (p_file) else $error("bad file");
  a_log: assert property (p_log) else $error("log lost");
endmodule // sync_chk
bind sync_cmd_engine sync_chk i_chk(.*);

/* dv/meas_model.sv */
// measurement partner: answers done requests after a delay
// assumes req is a pulse on mclk
`timescale 1ns/1ps
module meas_model(input wire logic mclk, reset, req,
  input wire logic [7:0] act, output logic [7:0] done);
  logic [3:0] cnt_q;
  // off channels never report; one switched off while awaited leaves sync pending
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin cnt_q <= '0; done <= '0; end
    else if (req) begin cnt_q <= 4'h9; done <= '0; end
    else if (cnt_q != 0) begin cnt_q <= cnt_q - 4'h1;
      if (cnt_q == 4'h1) done <= act; end
  end
endmodule // meas_model

/* dv/tb.sv */
// bench: command calls with expected results
// assumes SETTLE cut to 20 cycles
`timescale 1ns/1ps
module tb;
  logic mclk=0, reset=1, cmd_valid=0, oq_push, srq, mtrg, req, badf;
  logic rdy, ne=0, oq_rdy=0, logw=0, logp, ost;
  logic [7:0] act=8'h03, done, data, stb, esr, ev=8'h00, sre=8'h00;
  logic [7:0] evs, ese=8'h01;
  sync_cmd_pkg::cmd_s cmd='0;
  sync_cmd_pkg::store_req_s st;
  int n_errors=0, samples_checked=0, n;
  initial forever #4 mclk = ~mclk;
  always @(posedge mclk) if (oq_push && oq_rdy) ne <= 1;
  meas_model i_meas(.mclk, .reset, .req, .act, .done);
  sync_cmd_engine #(.SETTLE(20)) i_dut(.mclk, .reset, .cmd_valid,
    .cmd_in(cmd), .cmd_ready(rdy), .meas_active(act), .meas_done(done),
    .meas_done_req(req), .meas_trigger(mtrg), .get_msg(1'b0),
    .other_start(ost), .other_busy(1'b0), .oq_push, .oq_data(data),
    .oq_ready(oq_rdy), .oq_not_empty(ne), .sre_mask(sre), .ese_mask(ese),
    .evreg_set(ev), .esr_set(ev), .esr_q(esr), .evreg_sum_q(evs),
    .stb_q(stb), .srq, .error_queue_flush(), .bad_file_error(badf),
    .store_req(st), .store_busy(1'b0), .log_write(logw),
    .log_present_q(logp));
  task chk(string nm, logic [7:0] s, e);
    samples_checked++;
    if (s !== e) begin n_errors++;
      $display("wrong value %s exp %h seen %h", nm, e, s); end
  endtask
  task go(logic [3:0] c, logic [6:0] f);
    @(posedge mclk) cmd_valid <= 1;
    cmd <= '{sync_cmd_pkg::cmd_code_e'(c), 1'b1, f};
    @(negedge mclk);
    for (n=0; n<300 && rdy!==1; n++) @(negedge mclk);
    if (rdy !== 1'b1) begin n_errors++; finish_test(); end
    @(posedge mclk) cmd_valid <= 0;
  endtask
  task finish_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors==0 && samples_checked>0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // direct-read query: query first, enable bit 4 set while the answer stands, before the queue takes it
  initial begin
    repeat (3) @(posedge mclk);
    reset <= 0;
    @(posedge mclk) logw <= 1;
    @(posedge mclk) logw <= 0;
    go(4'h2, 0);
    for (n=0; n<99 && oq_push!==1; n++) @(negedge mclk);
    chk("delay", n>=15 && n<99, 1);
    chk("char", data, 8'h31);
    repeat (2) @(negedge mclk);
    chk("hold", oq_push, 1);
    @(posedge mclk) sre <= 8'h10;
    @(posedge mclk) oq_rdy <= 1;
    repeat (4) @(negedge mclk);
    chk("mav", stb[4], 1);
    chk("srq mav", srq, 1);
    @(posedge mclk) sre <= 8'h20;
    ev <= 8'h0f;
    @(posedge mclk) ev <= 8'h00;
    repeat (3) @(posedge mclk);
    go(4'h4, 0);
    repeat (3) @(negedge mclk);
    chk("esr", esr, 8'h00);
    chk("evreg", evs, 8'h00);
    chk("srq cls", srq, 0);
    chk("log", logp, 1);
    go(4'h1, 0);
    for (n=0; n<99 && esr[0]!==1; n++) @(negedge mclk);
    chk("opc", n>=15 && n<99, 1);
    repeat (3) @(negedge mclk);
    chk("srq esb", srq, 1);
    go(4'h3, 0);
    go(4'h5, 0);
    chk("wai", n>=15, 1);
    for (n=0; n<99 && mtrg!==1; n++) @(negedge mclk);
    chk("trg", n<99, 1);
    go(4'h8, 0);
    for (n=0; n<99 && ost!==1; n++) @(negedge mclk);
    chk("other", n<99, 1);
    go(4'h7, 7'h63);
    for (n=0; n<99 && st.valid!==1; n++) @(negedge mclk);
    chk("file", st.file_num, 8'h63);
    chk("save", st.is_save, 1);
    go(4'h6, 7'h05);
    for (n=0; n<99 && st.valid!==1; n++) @(negedge mclk);
    chk("recall", {st.is_save, st.file_num}, 8'h05);
    go(4'h6, 7'h64);
    for (n=0; n<99 && badf!==1; n++) @(negedge mclk);
    chk("bad", n<99, 1);
    finish_test();
  end
endmodule // tb
